/* spc_regs.sv */
// Serial control port and first PLL setting registers of the clock distribution block.
`timescale 1ns/1ps

// Behaviour
// - Configuration register writes apply immediately.
// - Bit 4 picks 16 or 8-bit instruction.
// - Bit 5 soft-resets registers, then self-clears.
// - Bit 6 selects least significant bit first.
// - Bit 7 moves read data onto bidirectional pin.
// - Register 04 holds six-bit swallow count.
// - Register 07 bit 2 enables reference loss.
// - Arming waits 3, 6, 12 or 24 cycles.
// - Register 08 bits 1:0 select pump mode.
module spc_regs
    import spc_pkg::*;
(
    input wire logic sys_clk_i,                // System clock, 100 MHz.
    input wire logic srst_i,                   // Synchronous reset, active high.
    input wire logic sclk_i,                   // Serial port clock from the host.
    input wire logic csb_n_i,                  // Serial chip select, active low.
    input wire logic sdio_i,                   // Bidirectional data pin, input side.
    output logic sdio_o,                       // Bidirectional data pin, output side.
    output logic sdio_oe_o,                    // Bidirectional data pin, drive enable.
    output logic serial_out_pin_o,             // Dedicated read data pin.
    output logic serial_out_pin_oe_o,          // Dedicated read data pin, drive enable.
    input wire logic lock_det_i,               // Lock detected, same clock.
    input wire logic pfd_tick_i,               // Detector cycle pulse, same clock.
    output logic long_instr_o,                 // Long instruction phase selected.
    output logic lsb_first_o,                  // Least significant bit first selected.
    output logic bidir_o,                      // Read data on bidirectional pin.
    output logic [5:0] swallow_count_o,        // Swallow counter value.
    output logic [12:0] main_count_o,          // Main counter value.
    output logic ref_loss_en_o,                // Reference loss detection enabled.
    output logic [1:0] ref_loss_delay_o,       // Reference loss initial delay code.
    output logic ref_loss_armed_o,             // Reference loss detection armed.
    output spc_pkg::spc_pump_e pump_mode_o     // Charge pump mode.
);
    import spc_pkg::*;

    // System domain state: the bank, its published snapshot and handshake flags.
    typedef struct packed {
        spc_bank_s bank;
        spc_bank_s snap;
        logic snap_req;
        logic wr_seen;
    } spc_sys_s;

    // Link domain state kept across frames: mirror of the bank and write word.
    typedef struct packed {
        spc_bank_s mirror;
        logic snap_ack;
        logic wr_tgl;
        logic [12:0] wr_addr;
        logic [7:0] wr_data;
    } spc_lnk_s;

    // Link domain state of the current frame, cleared while chip select is high.
    typedef struct packed {
        spc_phase_e ph;
        logic [4:0] cnt;
        logic [15:0] sh;
        logic rw;
        logic [1:0] width;
        logic [1:0] left;
        logic [12:0] addr;
        logic [7:0] rd;
        logic oe;
    } spc_frm_s;

    localparam spc_lnk_s LNK_RST = '{
        mirror: BANK_RST,
        snap_ack: 1'b0,
        wr_tgl: 1'b0,
        wr_addr: 13'h0000,
        wr_data: 8'h00
    };

    localparam spc_frm_s FRM_RST = '{
        ph: PH_INSTR,
        cnt: 5'h00,
        sh: 16'h0000,
        rw: 1'b0,
        width: 2'h0,
        left: 2'h0,
        addr: 13'h0000,
        rd: 8'h00,
        oe: 1'b0
    };

    spc_sys_s s_r;
    spc_sys_s s_nxt;
    spc_lnk_s l_r;
    spc_lnk_s l_nxt;
    spc_frm_s f_r;
    spc_frm_s f_nxt;

    logic [1:0] sys_sync_q;
    logic snap_req_sync;
    logic wr_fire;
    logic [7:0] wr_byte;
    logic lnk_lsb;
    logic lnk_long;
    logic lnk_bidir;
    logic out_bit;

    // Read value of one register from the link side mirror.
    function automatic logic [7:0] read_reg(input spc_bank_s b, input logic [12:0] a);
        logic [7:0] v;
        v = 8'h00;
        unique case (a)
            ADDR_CFG: v = b.cfg;
            ADDR_SWALLOW: v = b.swallow;
            ADDR_MAIN_HI: v = b.main_hi;
            ADDR_MAIN_LO: v = b.main_lo;
            ADDR_REF_LOSS: v = b.ref_loss;
            ADDR_PUMP: v = b.pump;
            default: v = 8'h00; // Unmapped addresses read as zero.
        endcase
        return v;
    endfunction

    // Write toggle and snapshot acknowledge come into the system domain.
    spc_sync #(
        .W(2)
    ) u_sys_sync (
        .clk_i(sys_clk_i),
        .rst_i(srst_i),
        .d_i({l_r.snap_ack, l_r.wr_tgl}),
        .q_o(sys_sync_q)
    );

    // Snapshot request goes out to the link domain.
    spc_sync #(
        .W(1)
    ) u_lnk_sync (
        .clk_i(sclk_i),
        .rst_i(srst_i),
        .d_i(s_r.snap_req),
        .q_o(snap_req_sync)
    );

    // System domain: commits serial writes and publishes snapshots of the bank.
    always_comb begin
        s_nxt = s_r;
        if (sys_sync_q[0] != s_r.wr_seen) begin
            s_nxt.wr_seen = sys_sync_q[0];
            unique case (l_r.wr_addr)
                ADDR_CFG: begin
                    if (l_r.wr_data[CFG_SOFT_RST_BIT]) begin
                        s_nxt.bank = BANK_RST;
                    end else begin
                        s_nxt.bank.cfg = l_r.wr_data & CFG_WR_MASK;
                    end
                end
                ADDR_SWALLOW: s_nxt.bank.swallow = l_r.wr_data & SWALLOW_MASK;
                ADDR_MAIN_HI: s_nxt.bank.main_hi = l_r.wr_data & MAIN_HI_MASK;
                ADDR_MAIN_LO: s_nxt.bank.main_lo = l_r.wr_data & MAIN_LO_MASK;
                ADDR_REF_LOSS: s_nxt.bank.ref_loss = l_r.wr_data & REF_LOSS_MASK;
                ADDR_PUMP: s_nxt.bank.pump = l_r.wr_data & PUMP_MASK;
                default: s_nxt.bank = s_r.bank;
            endcase
        end
        // A new snapshot goes out only after the previous one was taken.
        if (sys_sync_q[1] == s_r.snap_req && s_r.snap != s_r.bank) begin
            s_nxt.snap = s_r.bank;
            s_nxt.snap_req = ~s_r.snap_req;
        end
        if (srst_i) begin
            s_nxt.bank = BANK_RST;
            s_nxt.snap = BANK_RST;
            s_nxt.snap_req = 1'b0;
            s_nxt.wr_seen = 1'b0;
        end
    end

    // System domain register.
    always_ff @(posedge sys_clk_i) begin
        s_r <= s_nxt;
    end

    // Port settings seen by the frame logic come from the mirror.
    assign lnk_long = l_r.mirror.cfg[CFG_LONG_BIT];
    assign lnk_lsb = l_r.mirror.cfg[CFG_LSB_FIRST_BIT];
    assign lnk_bidir = l_r.mirror.cfg[CFG_BIDIR_BIT];

    // Frame logic: instruction decode, data shifting and address stepping.
    always_comb begin
        logic [15:0] instr_in;
        logic [7:0] byte_in;
        logic [4:0] ilen;
        logic [12:0] next_addr;
        instr_in = 16'h0000;
        byte_in = 8'h00;
        next_addr = 13'h0000;
        ilen = lnk_long ? INSTR_LONG_BITS : INSTR_SHORT_BITS;
        f_nxt = f_r;
        wr_fire = 1'b0;
        wr_byte = 8'h00;
        unique case (f_r.ph)
            PH_INSTR: begin
                // Either bit order lands the fields at the same positions.
                if (!lnk_lsb) begin
                    instr_in = {f_r.sh[14:0], sdio_i};
                end else if (lnk_long) begin
                    instr_in = {sdio_i, f_r.sh[15:1]};
                end else begin
                    instr_in = {8'h00, sdio_i, f_r.sh[7:1]};
                end
                f_nxt.sh = instr_in;
                f_nxt.cnt = f_r.cnt + 5'h01;
                if (f_r.cnt == ilen - 5'h01) begin
                    if (lnk_long) begin
                        f_nxt.rw = instr_in[15];
                        f_nxt.width = instr_in[14:13];
                        f_nxt.addr = instr_in[12:0];
                    end else begin
                        f_nxt.rw = instr_in[7];
                        f_nxt.width = instr_in[6:5];
                        f_nxt.addr = {8'h00, instr_in[4:0]};
                    end
                    f_nxt.left = f_nxt.width;
                    f_nxt.cnt = 5'h00;
                    f_nxt.sh = 16'h0000;
                    f_nxt.ph = PH_DATA;
                    f_nxt.rd = read_reg(l_r.mirror, f_nxt.addr);
                    f_nxt.oe = f_nxt.rw;
                end
            end
            PH_DATA: begin
                byte_in = lnk_lsb ? {sdio_i, f_r.sh[7:1]} : {f_r.sh[6:0], sdio_i};
                f_nxt.sh = {8'h00, byte_in};
                f_nxt.cnt = f_r.cnt + 5'h01;
                f_nxt.rd = lnk_lsb ? {1'b0, f_r.rd[7:1]} : {f_r.rd[6:0], 1'b0};
                if (f_r.cnt == BYTE_LAST_BIT) begin
                    f_nxt.cnt = 5'h00;
                    f_nxt.sh = 16'h0000;
                    wr_fire = ~f_r.rw;
                    wr_byte = byte_in;
                    // Least significant bit first counts up, otherwise down.
                    next_addr = lnk_lsb ? f_r.addr + 13'h0001 : f_r.addr - 13'h0001;
                    if (f_r.width != XFER_STREAM && f_r.left == 2'h0) begin
                        f_nxt.ph = PH_DONE;
                        f_nxt.oe = 1'b0;
                    end else begin
                        if (f_r.width != XFER_STREAM) begin
                            f_nxt.left = f_r.left - 2'h1;
                        end
                        f_nxt.addr = next_addr;
                        f_nxt.rd = read_reg(l_r.mirror, next_addr);
                    end
                end
            end
            PH_DONE: begin
                f_nxt = f_r; // Extra clocks in a finished frame are ignored.
            end
            default: begin
                f_nxt = FRM_RST;
            end
        endcase
    end

    // Frame register, cleared whenever chip select is released.
    always_ff @(posedge sclk_i or posedge csb_n_i) begin
        if (csb_n_i) begin
            f_r <= FRM_RST;
        end else begin
            f_r <= f_nxt;
        end
    end

    // Link domain: takes snapshots and holds each written byte for the system side.
    always_comb begin
        l_nxt = l_r;
        if (snap_req_sync != l_r.snap_ack) begin
            l_nxt.mirror = s_r.snap;
            l_nxt.snap_ack = snap_req_sync;
        end
        if (wr_fire) begin
            l_nxt.wr_addr = f_r.addr;
            l_nxt.wr_data = wr_byte;
            l_nxt.wr_tgl = ~l_r.wr_tgl;
        end
    end

    // Link register, kept across frames.
    always_ff @(posedge sclk_i or posedge srst_i) begin
        if (srst_i) begin
            l_r <= LNK_RST;
        end else begin
            l_r <= l_nxt;
        end
    end

    // Read data leaves on one of two pins depending on the port mode.
    assign out_bit = lnk_lsb ? f_r.rd[0] : f_r.rd[7];
    assign sdio_o = out_bit;
    assign sdio_oe_o = f_r.oe & lnk_bidir;
    assign serial_out_pin_o = out_bit;
    assign serial_out_pin_oe_o = f_r.oe & ~lnk_bidir;

    // Reference loss arming delay.
    spc_ref_loss_arm u_arm (
        .sys_clk_i(sys_clk_i),
        .srst_i(srst_i),
        .enable_i(s_r.bank.ref_loss[REF_LOSS_EN_BIT]),
        .delay_code_i(s_r.bank.ref_loss[REF_LOSS_DLY_MSB:REF_LOSS_DLY_LSB]),
        .lock_det_i(lock_det_i),
        .pfd_tick_i(pfd_tick_i),
        .armed_o(ref_loss_armed_o)
    );

    // Settings driven straight from the bank.
    assign long_instr_o = s_r.bank.cfg[CFG_LONG_BIT];
    assign lsb_first_o = s_r.bank.cfg[CFG_LSB_FIRST_BIT];
    assign bidir_o = s_r.bank.cfg[CFG_BIDIR_BIT];
    assign swallow_count_o = s_r.bank.swallow[5:0];
    assign main_count_o = {s_r.bank.main_hi[4:0], s_r.bank.main_lo};
    assign ref_loss_en_o = s_r.bank.ref_loss[REF_LOSS_EN_BIT];
    assign ref_loss_delay_o = s_r.bank.ref_loss[REF_LOSS_DLY_MSB:REF_LOSS_DLY_LSB];
    assign pump_mode_o = spc_pump_e'(s_r.bank.pump[1:0]);
endmodule

/* spc_pkg.sv */
// Package with register map, field layout, reset values and codes of the serial control port.
package spc_pkg;

    // Register byte addresses on the serial control port.
    localparam logic [12:0] ADDR_CFG = 13'h0000;
    localparam logic [12:0] ADDR_SWALLOW = 13'h0004;
    localparam logic [12:0] ADDR_MAIN_HI = 13'h0005;
    localparam logic [12:0] ADDR_MAIN_LO = 13'h0006;
    localparam logic [12:0] ADDR_REF_LOSS = 13'h0007;
    localparam logic [12:0] ADDR_PUMP = 13'h0008;

    // Field positions inside the configuration register.
    localparam int unsigned CFG_LONG_BIT = 4;
    localparam int unsigned CFG_SOFT_RST_BIT = 5;
    localparam int unsigned CFG_LSB_FIRST_BIT = 6;
    localparam int unsigned CFG_BIDIR_BIT = 7;

    // Field positions inside the reference loss control register.
    localparam int unsigned REF_LOSS_EN_BIT = 2;
    localparam int unsigned REF_LOSS_DLY_LSB = 5;
    localparam int unsigned REF_LOSS_DLY_MSB = 6;

    // Writable bits of each register; every other bit is stored as zero.
    localparam logic [7:0] CFG_WR_MASK = 8'hD0;
    localparam logic [7:0] SWALLOW_MASK = 8'h3F;
    localparam logic [7:0] MAIN_HI_MASK = 8'h1F;
    localparam logic [7:0] MAIN_LO_MASK = 8'hFF;
    localparam logic [7:0] REF_LOSS_MASK = 8'h64;
    localparam logic [7:0] PUMP_MASK = 8'h03;

    // Values after reset.
    localparam logic [7:0] CFG_RST = 8'h10;
    localparam logic [7:0] SWALLOW_RST = 8'h00;
    localparam logic [7:0] MAIN_HI_RST = 8'h00;
    localparam logic [7:0] MAIN_LO_RST = 8'h00;
    localparam logic [7:0] REF_LOSS_RST = 8'h00;
    localparam logic [7:0] PUMP_RST = 8'h00;

    // Detector cycles waited before reference loss detection arms, per delay code.
    localparam logic [4:0] REF_LOSS_DLY_0 = 5'h03;
    localparam logic [4:0] REF_LOSS_DLY_1 = 5'h06;
    localparam logic [4:0] REF_LOSS_DLY_2 = 5'h0C;
    localparam logic [4:0] REF_LOSS_DLY_3 = 5'h18;

    // Serial frame bit counts.
    localparam logic [4:0] INSTR_LONG_BITS = 5'h10;
    localparam logic [4:0] INSTR_SHORT_BITS = 5'h08;
    localparam logic [4:0] BYTE_LAST_BIT = 5'h07;
    localparam logic [1:0] XFER_STREAM = 2'h3;

    // Charge pump modes.
    typedef enum logic [1:0] {
        PUMP_HIZ = 2'b00,
        PUMP_UP = 2'b01,
        PUMP_DOWN = 2'b10,
        PUMP_NORMAL = 2'b11
    } spc_pump_e;

    // Phases of a serial frame.
    typedef enum logic [1:0] {
        PH_INSTR = 2'b00,
        PH_DATA = 2'b01,
        PH_DONE = 2'b10
    } spc_phase_e;

    // Whole register bank, also used as the snapshot passed to the link domain.
    typedef struct packed {
        logic [7:0] cfg;
        logic [7:0] swallow;
        logic [7:0] main_hi;
        logic [7:0] main_lo;
        logic [7:0] ref_loss;
        logic [7:0] pump;
    } spc_bank_s;

    localparam spc_bank_s BANK_RST = '{
        cfg: CFG_RST,
        swallow: SWALLOW_RST,
        main_hi: MAIN_HI_RST,
        main_lo: MAIN_LO_RST,
        ref_loss: REF_LOSS_RST,
        pump: PUMP_RST
    };

endpackage

/* spc_sync.sv */
// Three-stage synchroniser with agreement filter for independent toggle or level bits.
`timescale 1ns/1ps
module spc_sync #(
    parameter int W = 1
) (
    input wire logic clk_i,          // Destination domain clock.
    input wire logic rst_i,          // Asynchronous reset, active high.
    input wire logic [W-1:0] d_i,    // Bits from the other domain.
    output logic [W-1:0] q_o         // Filtered bits in this domain.
);
    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
        logic [W-1:0] s3;
        logic [W-1:0] val;
    } spc_sync_s;

    spc_sync_s q_r;
    spc_sync_s q_nxt;

    // A bit takes a new value only once the second and third stages agree.
    always_comb begin
        q_nxt = q_r;
        q_nxt.s1 = d_i;
        q_nxt.s2 = q_r.s1;
        q_nxt.s3 = q_r.s2;
        q_nxt.val = ((q_r.s2 ~^ q_r.s3) & q_r.s3) | ((q_r.s2 ^ q_r.s3) & q_r.val);
    end

    // The stages only ever reset to zero.
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            q_r <= '0;
        end else begin
            q_r <= q_nxt;
        end
    end

    assign q_o = q_r.val;
endmodule

/* spc_ref_loss_arm.sv */
// Arming delay for reference loss detection, counted in detector cycles after first lock.
`timescale 1ns/1ps
module spc_ref_loss_arm
    import spc_pkg::*;
(
    input wire logic sys_clk_i,          // System clock.
    input wire logic srst_i,             // Synchronous reset, active high.
    input wire logic enable_i,           // Reference loss detection enabled.
    input wire logic [1:0] delay_code_i, // Initial delay code.
    input wire logic lock_det_i,         // Lock detected, level.
    input wire logic pfd_tick_i,         // One pulse per phase_freq_detector cycle.
    output logic armed_o                 // Detection armed, level.
);
    typedef struct packed {
        logic seen;
        logic [4:0] cnt;
        logic armed;
    } spc_arm_s;

    spc_arm_s q_r;
    spc_arm_s q_nxt;
    logic [4:0] target;

    // Delay code to detector cycle count.
    always_comb begin
        unique case (delay_code_i)
            2'b00: target = REF_LOSS_DLY_0;
            2'b01: target = REF_LOSS_DLY_1;
            2'b10: target = REF_LOSS_DLY_2;
            2'b11: target = REF_LOSS_DLY_3;
        endcase
    end

    // Waits for first lock, then counts detector cycles up to the target.
    always_comb begin
        q_nxt = q_r;
        if (srst_i || !enable_i) begin
            q_nxt = '0;
        end else if (!q_r.seen) begin
            if (lock_det_i) begin
                q_nxt.seen = 1'b1;
                q_nxt.cnt = '0;
            end
        end else if (!q_r.armed && pfd_tick_i) begin
            if (q_r.cnt == target - 5'h01) begin
                q_nxt.armed = 1'b1;
            end else begin
                q_nxt.cnt = q_r.cnt + 5'h01;
            end
        end
    end

    // State register.
    always_ff @(posedge sys_clk_i) begin
        q_r <= q_nxt;
    end

    assign armed_o = q_r.armed;
endmodule

/* spc_regs_assertions.sv */
// Checker of port relations of the serial control register block.
`timescale 1ns/1ps
module spc_regs_chk
    import spc_pkg::*;
(
    input wire logic sys_clk_i,             // System clock.
    input wire logic srst_i,                // Synchronous reset.
    input wire logic sclk_i,                // Serial port clock.
    input wire logic csb_n_i,               // Chip select, active low.
    input wire logic sdio_oe_o,             // Bidirectional pin drive enable.
    input wire logic serial_out_pin_oe_o,   // Dedicated pin drive enable.
    input wire logic pfd_tick_i,            // Detector cycle pulse.
    input wire logic long_instr_o,          // Long instruction selected.
    input wire logic lsb_first_o,           // Bit order selected.
    input wire logic bidir_o,               // Bidirectional mode selected.
    input wire logic [5:0] swallow_count_o, // Swallow counter value.
    input wire logic [12:0] main_count_o,   // Main counter value.
    input wire logic ref_loss_en_o,         // Reference loss enable.
    input wire logic [1:0] ref_loss_delay_o, // Reference loss delay code.
    input wire logic ref_loss_armed_o,      // Reference loss armed.
    input wire spc_pkg::spc_pump_e pump_mode_o // Charge pump mode.
);
    logic [4:0] idle_cnt_r;

    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (srst_i);

    // Counts quiet cycles since chip select went high, saturating.
    always_ff @(posedge sys_clk_i) begin
        if (srst_i || !csb_n_i) begin
            idle_cnt_r <= 5'h00;
        end else if (idle_cnt_r != 5'h1F) begin
            idle_cnt_r <= idle_cnt_r + 5'h01;
        end
    end

    property p_rst_vals;
        $fell(srst_i) |-> long_instr_o && !lsb_first_o && !bidir_o && !ref_loss_en_o
            && swallow_count_o == 6'h00 && main_count_o == 13'h0000 && pump_mode_o == PUMP_HIZ;
    endproperty
    a_rst_vals: assert property (p_rst_vals) else $error("Bad values after reset.");
    property p_sdio_mode;
        sdio_oe_o |-> bidir_o && !serial_out_pin_oe_o;
    endproperty
    a_sdio_mode: assert property (p_sdio_mode) else $error("Data pin driven out of mode.");
    property p_sop_mode;
        serial_out_pin_oe_o |-> !bidir_o;
    endproperty
    a_sop_mode: assert property (p_sop_mode) else $error("Output pin driven in bidir mode.");
    property p_csb_idle;
        csb_n_i |-> !sdio_oe_o && !serial_out_pin_oe_o;
    endproperty
    a_csb_idle: assert property (p_csb_idle) else $error("Pin driven without a frame.");
    property p_quiet;
        idle_cnt_r > 5'h14 |-> $stable({long_instr_o, lsb_first_o, bidir_o, swallow_count_o,
            main_count_o, ref_loss_en_o, ref_loss_delay_o, pump_mode_o});
    endproperty
    a_quiet: assert property (p_quiet) else $error("Setting changed with no frame.");
    property p_arm_rise;
        $rose(ref_loss_armed_o) |-> ref_loss_en_o && ($past(pfd_tick_i) || pfd_tick_i);
    endproperty
    a_arm_rise: assert property (p_arm_rise) else $error("Armed without tick or enable.");
    property p_arm_hold;
        ref_loss_armed_o && ref_loss_en_o |=> ref_loss_armed_o;
    endproperty
    a_arm_hold: assert property (p_arm_hold) else $error("Armed dropped while enabled.");
    property p_en_off;
        $fell(ref_loss_en_o) |-> ##[0:2] !ref_loss_armed_o;
    endproperty
    a_en_off: assert property (p_en_off) else $error("Armed stays after disable.");
    property p_read_len;
        @(posedge sclk_i) disable iff (srst_i || csb_n_i)
        $rose(sdio_oe_o || serial_out_pin_oe_o) |-> (sdio_oe_o || serial_out_pin_oe_o) [*8];
    endproperty
    a_read_len: assert property (p_read_len) else $error("Read byte not eight bits long.");
    c_sdio_read: cover property ($rose(sdio_oe_o));
    c_sop_read: cover property ($rose(serial_out_pin_oe_o));
    c_armed: cover property ($rose(ref_loss_armed_o));
endmodule

bind spc_regs spc_regs_chk i_spc_regs_chk (.*);

/* spc_host.sv */
// Behavioural serial host that runs frames on the control port.
`timescale 1ns/1ps
module spc_host (
    output logic sclk_o,     // Port clock, also run for idle clocks after each frame.
    output logic csb_n_o,    // Chip select, active low.
    output logic sdio_o,     // Data towards the device.
    input wire logic sdio_i, // Resolved bidirectional pin.
    input wire logic sop_i   // Dedicated read pin.
);
    logic long_m = 1'b1;
    logic lsb_m = 1'b0;
    logic bidir_m = 1'b0;

    // Lines idle with the clock stopped low.
    initial begin
        sclk_o = 1'b0;
        csb_n_o = 1'b1;
        sdio_o = 1'b0;
    end

    // Sets one bit after a falling edge, then gives the rising edge that takes it.
    task automatic put_bit(input logic b);
        sdio_o = b;
        #6 sclk_o = 1'b1;
        #6 sclk_o = 1'b0;
    endtask

    // One single-byte frame, then idle clocks with chip select high so the mirror refreshes.
    task automatic xfer(input logic rw, input logic [12:0] a, input logic [7:0] wd,
            output logic [7:0] rd);
        logic [15:0] ins;
        int n;
        ins = long_m ? {rw, 2'b00, a} : {8'h00, rw, 2'b00, a[4:0]};
        n = long_m ? 16 : 8;
        rd = 8'h00;
        csb_n_o = 1'b0;
        for (int i = n - 1; i >= 0; i--) begin
            put_bit(ins[lsb_m ? n - 1 - i : i]);
        end
        for (int i = 7; i >= 0; i--) begin
            if (!rw) begin
                put_bit(wd[lsb_m ? 7 - i : i]);
            end else begin
                sdio_o = ~sdio_o;
                #6 rd[lsb_m ? 7 - i : i] = bidir_m ? sdio_i : sop_i;
                sclk_o = 1'b1;
                #6 sclk_o = 1'b0;
            end
        end
        sdio_o = ~sdio_o;
        #6 csb_n_o = 1'b1;
        repeat (20) put_bit(sdio_o);
    endtask
endmodule

/* spc_regs_tb.sv */
// Testbench of the serial control register block.
`timescale 1ns/1ps
module spc_regs_tb;
    import spc_pkg::*;
    typedef struct {logic wr; logic [12:0] a; logic [7:0] d; logic [7:0] e;} spc_row_s;
    logic sys_clk_i = 1'b0;
    logic srst_i;
    logic lock_det_i = 1'b0;
    logic pfd_tick_i = 1'b0;
    logic sclk, csb_n, h_sdio, sdio_w, sop_w, sdio_o, sdio_oe_o, sop_o, sop_oe_o;
    logic long_instr_o, lsb_first_o, bidir_o, ref_loss_en_o, ref_loss_armed_o;
    logic [5:0] swallow_count_o;
    logic [12:0] main_count_o;
    logic [1:0] ref_loss_delay_o;
    spc_pump_e pump_mode_o;
    int fails = 0;
    int checks_done = 0;
    int cyc = 0;
    spc_row_s rows [8] = '{
        '{1'b0, ADDR_CFG, 8'h00, 8'h10},
        '{1'b0, ADDR_PUMP, 8'h00, 8'h00},
        '{1'b1, ADDR_SWALLOW, 8'hFF, 8'h3F},
        '{1'b1, ADDR_MAIN_HI, 8'hFF, 8'h1F},
        '{1'b1, ADDR_MAIN_LO, 8'hA5, 8'hA5},
        '{1'b1, ADDR_REF_LOSS, 8'hFF, 8'h64},
        '{1'b1, ADDR_PUMP, 8'hFF, 8'h03},
        '{1'b1, 13'h0002, 8'hFF, 8'h00}};

    always #5 sys_clk_i = ~sys_clk_i;

    // Pin levels seen by each party; an undriven dedicated pin shows a moving pattern.
    assign sdio_w = sdio_oe_o ? sdio_o : h_sdio;
    assign sop_w = sop_oe_o ? sop_o : sys_clk_i;

    spc_host i_spc_host (.sclk_o(sclk), .csb_n_o(csb_n), .sdio_o(h_sdio), .sdio_i(sdio_w),
        .sop_i(sop_w));

    spc_regs i_spc_regs (.sys_clk_i(sys_clk_i), .srst_i(srst_i), .sclk_i(sclk),
        .csb_n_i(csb_n), .sdio_i(sdio_w), .sdio_o(sdio_o), .sdio_oe_o(sdio_oe_o),
        .serial_out_pin_o(sop_o), .serial_out_pin_oe_o(sop_oe_o), .lock_det_i(lock_det_i),
        .pfd_tick_i(pfd_tick_i), .long_instr_o(long_instr_o), .lsb_first_o(lsb_first_o),
        .bidir_o(bidir_o), .swallow_count_o(swallow_count_o), .main_count_o(main_count_o),
        .ref_loss_en_o(ref_loss_en_o), .ref_loss_delay_o(ref_loss_delay_o),
        .ref_loss_armed_o(ref_loss_armed_o), .pump_mode_o(pump_mode_o));

    // Compares one value and counts the outcome.
    task automatic chk(input logic [12:0] got, input logic [12:0] exp);
        checks_done++;
        if (got !== exp) begin
            fails++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // Prints the counts and the verdict, then ends the run.
    task automatic tally_and_finish;
        $display("Comparisons %0d, mismatches %0d", checks_done, fails);
        if (fails == 0 && checks_done > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    // Cuts a hang short.
    always @(posedge sys_clk_i) begin
        cyc++;
        if (cyc == 20000) begin
            fails++;
            tally_and_finish();
        end
    end

    // Main sequence.
    initial begin
        logic [7:0] v;
        int n;
        srst_i <= 1'b1;
        repeat (10) @(posedge sys_clk_i);
        srst_i <= 1'b0;
        @(negedge sys_clk_i);
        chk(13'({long_instr_o, lsb_first_o, bidir_o, ref_loss_en_o, pump_mode_o}), 13'h0020);
        foreach (rows[k]) begin
            if (rows[k].wr) begin
                i_spc_host.xfer(1'b0, rows[k].a, rows[k].d, v);
            end
            i_spc_host.xfer(1'b1, rows[k].a, 8'h00, v);
            chk(13'(v), 13'(rows[k].e));
        end
        chk(main_count_o, 13'h1FA5);
        chk(13'(swallow_count_o), 13'h003F);
        chk(13'({ref_loss_en_o, ref_loss_delay_o}), 13'h0007);
        for (int c = 0; c < 4; c++) begin
            i_spc_host.xfer(1'b0, ADDR_PUMP, 8'(c), v);
            chk(13'(pump_mode_o), 13'(c));
        end
        for (int c = 0; c < 4; c++) begin
            i_spc_host.xfer(1'b0, ADDR_REF_LOSS, 8'(8'h04 | (c << 5)), v);
            chk(13'(ref_loss_delay_o), 13'(c));
            n = 3 << c;
            @(posedge sys_clk_i) lock_det_i <= 1'b1;
            for (int t = 1; t <= n; t++) begin
                @(posedge sys_clk_i) pfd_tick_i <= 1'b1;
                @(posedge sys_clk_i) pfd_tick_i <= 1'b0;
                @(posedge sys_clk_i);
                #1;
                chk(13'(ref_loss_armed_o), 13'(t == n));
            end
            i_spc_host.xfer(1'b0, ADDR_REF_LOSS, 8'h00, v);
            @(posedge sys_clk_i) lock_det_i <= 1'b0;
            chk(13'({ref_loss_en_o, ref_loss_armed_o}), 13'h0000);
        end
        i_spc_host.xfer(1'b0, ADDR_CFG, 8'hC0, v);
        chk(13'({long_instr_o, lsb_first_o, bidir_o}), 13'h0003);
        i_spc_host.long_m = 1'b0;
        i_spc_host.lsb_m = 1'b1;
        i_spc_host.bidir_m = 1'b1;
        i_spc_host.xfer(1'b0, ADDR_SWALLOW, 8'h15, v);
        chk(13'(swallow_count_o), 13'h0015);
        i_spc_host.xfer(1'b1, ADDR_SWALLOW, 8'h00, v);
        chk(13'(v), 13'h0015);
        i_spc_host.xfer(1'b1, ADDR_CFG, 8'h00, v);
        chk(13'(v), 13'h00C0);
        i_spc_host.xfer(1'b0, ADDR_CFG, 8'h20, v);
        i_spc_host.long_m = 1'b1;
        i_spc_host.lsb_m = 1'b0;
        i_spc_host.bidir_m = 1'b0;
        chk(13'({long_instr_o, lsb_first_o, bidir_o, swallow_count_o}), 13'h0100);
        chk(13'(pump_mode_o), 13'h0000);
        i_spc_host.xfer(1'b1, ADDR_CFG, 8'h00, v);
        chk(13'(v), 13'h0010);
        tally_and_finish();
    end
endmodule
